/* rtl/emc_defines.svh */
// Purpose: Constants for the emulation mode control block.
// Assumes: One machine cycle is six states S1..S6 at one state per clock.
// Notes:   Included by the package and the control module.
//
// Contract
// [RQ1] Normal mode: select low program, high data
// [RQ2] Space low: strobes access registers, PC, RAM
// [RQ3] Space high: open external memory, pull strobes
// [RQ4] Standard: port0 floats, port2 float optional
// [RQ5] Undriven space select reads as low
// [RQ6] Request high freezes clock and states
// [RQ7] Emulation allows register, RAM, memory access
// [RQ8] Request low releases clock, resumes mode
// [RQ9] Active rises at end of S1
// [RQ10] Exit loads holding register with NOP
// [RQ11] Active drops four states after exit
// [RQ12] Pulse marks S1 of every cycle
// [RQ13] Power-on type from select and access pins
// [RQ14] Type latched at power-on, never changes
// [RQ15] Default advanced, request pulled low
// [RQ16] Advanced normal uses separate data/address ports
// [RQ17] Advanced normal strobes gate external memory
// [RQ18] Hold in S2; request sampled end S1
// [RQ19] Freeze pins and contents during emulation
// [RQ20] Active stays high entry through exit NOP
`ifndef EMC_DEFINES_SVH
`define EMC_DEFINES_SVH

`define EMC_STATES_PER_CYCLE 3'h6
`define EMC_STATE_S1         3'h0
`define EMC_STATE_S2         3'h1
`define EMC_STATE_S4         3'h3
`define EMC_EXIT_STATES      3'h4
`define EMC_NOP_OPCODE       8'h00
`define EMC_RAM_DEPTH        256
`define EMC_SPACE_INTERNAL   1'b0
`define EMC_SPACE_EXTERNAL   1'b1
`define EMC_SEL_PC_LO        8'h00
`define EMC_SEL_PC_HI        8'h01
`define EMC_SEL_IR           8'h02

`endif

/* rtl/emc_pkg.sv */
// Purpose: Types for the emulation mode control block.
// Assumes: Nothing beyond the defines header.
// Notes:   States are one-hot.
`include "emc_defines.svh"
package emc_pkg;
	typedef enum logic [3:0] {
		EMC_RUN   = 4'h1,
		EMC_ENTER = 4'h2,
		EMC_HALT  = 4'h4,
		EMC_EXIT  = 4'h8
	} emc_state_t;

	typedef struct packed {
		logic        wr_n;
		logic        rd_n;
		logic        sel_hi;
		logic [7:0]  addr;
		logic [7:0]  wdata;
	} emc_acc_t;

	typedef struct packed {
		logic [7:0]  data_out;
		logic [7:0]  addr_low;
		logic [7:0]  addr_high;
		logic        pse_n;
		logic        wr_n;
		logic        rd_n;
	} emc_mem_t;
endpackage : emc_pkg

/* rtl/emc_ctrl.sv */
// Purpose: Emulation freeze, release, type latch and space indication.
// Assumes: Core request inputs synchronous to core_clk.
// Notes:   The core's own fetch/execute is abstracted to requests here.
`timescale 1ns/1ns
`include "emc_defines.svh"
module emc_ctrl #(
	parameter int RAM_DEPTH = `EMC_RAM_DEPTH
) (
	// Clock and reset
	input  wire logic          core_clk,
	input  wire logic          rst_n,
	// Strap pins
	input  wire logic          type_select_n,
	input  wire logic          external_access_n,
	// Emulation control pins
	input  wire logic          emulation_request,
	input  wire logic          addr_space_select_i,
	input  wire logic          addr_space_select_drv,
	output logic               addr_space_select_o,
	output logic               addr_space_select_oe_n,
	output logic               emulation_active,
	output logic               state1_clock_out,
	// Controller access bus
	input  wire emc_pkg::emc_acc_t acc,
	output logic [7:0]         acc_rdata,
	// Core memory requests
	input  wire logic          core_data_access,
	input  wire emc_pkg::emc_mem_t core_mem,
	input  wire logic [7:0]    port2_float_control,
	// Memory-side outputs
	output emc_pkg::emc_mem_t  mem_out,
	output logic               strobe_pullup_en,
	output logic               port0_float,
	output logic               port2_float,
	output logic               advanced_type,
	output logic               core_run,
	output logic [7:0]         instruction_holding_reg,
	output logic [15:0]        pc_value
);
	import emc_pkg::*;

	// ****************************************************
	// State sequencer
	// ****************************************************
	emc_state_t  st_q;
	emc_state_t  st_d;
	logic [2:0]  phase_q;
	logic [2:0]  exit_cnt_q;
	logic        strap_done_q;
	logic        adv_q;
	logic        req_q;
	logic [7:0]  ir_q;
	logic [15:0] pc_q;
	logic [7:0]  ram_q [RAM_DEPTH];
	logic [7:0]  rdata_q;
	emc_mem_t    mem_q;

	wire frozen     = (st_q == EMC_HALT);
	wire at_s1_end  = (phase_q == `EMC_STATE_S1);
	wire last_phase = (phase_q == `EMC_STATES_PER_CYCLE - 3'h1);
	// Undriven select pin resolves to internal space.
	wire space_hi   = addr_space_select_drv & addr_space_select_i; // RQ5
	wire emu_wr     = frozen & ~space_hi & ~acc.wr_n; // RQ2
	wire emu_rd     = frozen & ~space_hi & ~acc.rd_n; // RQ2

	// Request sampled only at the end of S1, then the core stops in S2.
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			EMC_RUN:   if (req_q && at_s1_end) st_d = EMC_ENTER; // RQ18
			EMC_ENTER: st_d = EMC_HALT; // RQ6
			EMC_HALT:  if (!req_q) st_d = EMC_EXIT; // RQ8
			EMC_EXIT:  if (exit_cnt_q == `EMC_EXIT_STATES - 3'h1)
				st_d = EMC_RUN; // RQ11
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q       <= EMC_RUN;
			req_q      <= 1'b0;
			phase_q    <= `EMC_STATE_S1;
			exit_cnt_q <= 3'h0;
		end else begin
			st_q  <= st_d;
			req_q <= emulation_request;
			// States stop from entry on, so the core holds in S2.
			if (st_q == EMC_RUN || st_q == EMC_EXIT) begin // RQ6 RQ18
				phase_q <= last_phase ? `EMC_STATE_S1 : phase_q + 3'h1;
			end
			exit_cnt_q <= (st_q == EMC_EXIT) ? exit_cnt_q + 3'h1 : 3'h0;
		end
	end

	// ****************************************************
	// Type latch
	// ****************************************************
	// Advanced when select high/floating and access low; default pulls.
	wire adv_strap = type_select_n & ~external_access_n; // RQ13 RQ15

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			strap_done_q <= 1'b0;
			adv_q        <= 1'b1;
		end else if (!strap_done_q) begin
			strap_done_q <= 1'b1;
			adv_q        <= adv_strap; // RQ14
		end
	end

	// ****************************************************
	// Controller access to registers, PC and RAM
	// ****************************************************
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ir_q    <= `EMC_NOP_OPCODE;
			pc_q    <= 16'h0000;
			rdata_q <= 8'h00;
		end else begin
			if (st_q == EMC_HALT && !req_q) begin
				ir_q <= `EMC_NOP_OPCODE; // RQ10
			end else if (emu_wr && acc.sel_hi &&
					acc.addr == `EMC_SEL_IR) begin
				ir_q <= acc.wdata; // RQ7
			end
			if (emu_wr && acc.sel_hi && acc.addr == `EMC_SEL_PC_LO) begin
				pc_q[7:0] <= acc.wdata; // RQ7
			end
			if (emu_wr && acc.sel_hi && acc.addr == `EMC_SEL_PC_HI) begin
				pc_q[15:8] <= acc.wdata; // RQ7
			end
			if (emu_rd) begin
				rdata_q <= acc.sel_hi ? sfr_read(acc.addr)
					: ram_q[acc.addr]; // RQ7
			end
		end
	end

	// RAM holds its contents while running; only the controller writes here.
	always_ff @(posedge core_clk) begin
		if (emu_wr && !acc.sel_hi) begin
			ram_q[acc.addr] <= acc.wdata; // RQ7
		end
	end

	function automatic logic [7:0] sfr_read(input logic [7:0] a);
		unique case (a)
			`EMC_SEL_PC_LO: sfr_read = pc_q[7:0];
			`EMC_SEL_PC_HI: sfr_read = pc_q[15:8];
			`EMC_SEL_IR:    sfr_read = ir_q;
			default:        sfr_read = 8'h00;
		endcase
	endfunction : sfr_read

	// ****************************************************
	// Memory pins
	// ****************************************************
	// While halted, pins hold their last level except addr_low and data_out, which follow the access bus in space high.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_q <= '{data_out: 8'h00, addr_low: 8'h00, addr_high: 8'h00,
				pse_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1};
		end else if (!frozen && adv_q) begin
			mem_q <= core_mem; // RQ16 RQ17
		end else if (frozen && space_hi) begin
			mem_q.addr_low <= acc.addr; // RQ3
			mem_q.data_out <= acc.wdata; // RQ3
		end
	end // RQ19

	assign mem_out                = mem_q;
	assign strobe_pullup_en       = frozen & space_hi; // RQ3
	assign port0_float            = frozen & space_hi & ~adv_q; // RQ4
	assign port2_float            = port0_float
		& (port2_float_control != 8'h00); // RQ4
	// Space select is driven only in normal mode.
	assign addr_space_select_o    = core_data_access; // RQ1
	assign addr_space_select_oe_n = (st_q != EMC_RUN);
	assign emulation_active       = (st_q != EMC_RUN); // RQ9 RQ20
	assign state1_clock_out       = at_s1_end & ~frozen; // RQ12
	assign advanced_type          = adv_q;
	assign core_run               = ~frozen;
	assign instruction_holding_reg = ir_q;
	assign pc_value               = pc_q;
	assign acc_rdata              = rdata_q;
endmodule : emc_ctrl

/* tb/emc_ctrl_chk.sv */
// Purpose: Port checks for emc_ctrl.
// Assumes: One state per clock, six states a cycle.
// Notes:   Bound to every emc_ctrl instance.
`timescale 1ns/1ns
module emc_chk (
	// Clock, reset and pins
	input wire logic       core_clk,
	input wire logic       rst_n,
	input wire logic       emulation_request,
	input wire logic       core_data_access,
	input wire logic       addr_space_select_i,
	input wire logic       addr_space_select_drv,
	input wire logic       addr_space_select_o,
	input wire logic       addr_space_select_oe_n,
	input wire logic       emulation_active,
	input wire logic       state1_clock_out,
	input wire logic       core_run,
	input wire logic       advanced_type,
	input wire logic       strobe_pullup_en,
	input wire logic [7:0] instruction_holding_reg
);
	logic [1:0] age_q;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) age_q <= 2'h0;
		else if (age_q != 2'h3) age_q <= age_q + 2'h1;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	AST_SPACE: assert property (
		!addr_space_select_oe_n |-> addr_space_select_o == core_data_access)
		else $error("space select wrong");
	AST_RELEASE: assert property (
		emulation_active |-> addr_space_select_oe_n)
		else $error("space pin driven in emulation");
	AST_PULL: assert property (
		!core_run && emulation_active && addr_space_select_i
		&& addr_space_select_drv |-> strobe_pullup_en)
		else $error("strobe pull-up missing");
	AST_FREEZE: assert property (!core_run |-> !state1_clock_out)
		else $error("state pulse while frozen");
	AST_PERIOD: assert property (
		state1_clock_out |=> !state1_clock_out [*5])
		else $error("state pulse spacing wrong");
	AST_ENTER: assert property (
		$rose(emulation_active) |-> $past(emulation_request, 2))
		else $error("active without request");
	AST_NOP: assert property (
		$fell(emulation_active) |-> $past(instruction_holding_reg) == 8'h00)
		else $error("holding register not cleared");
	AST_EXIT: assert property (
		$fell(emulation_active) |-> $past(emulation_active, 4) && core_run)
		else $error("exit too short");
	AST_HOLD: assert property (
		emulation_active && emulation_request |=> emulation_active)
		else $error("active dropped under request");
	AST_TYPE: assert property (age_q == 2'h3 |-> $stable(advanced_type))
		else $error("type changed");
endmodule : emc_chk
bind emc_ctrl emc_chk i_chk (.core_clk, .rst_n, .emulation_request,
	.core_data_access, .addr_space_select_i, .addr_space_select_drv,
	.addr_space_select_o, .addr_space_select_oe_n, .emulation_active,
	.state1_clock_out, .core_run, .advanced_type, .strobe_pullup_en,
	.instruction_holding_reg);

/* tb/emc_ice_model.sv */
// Purpose: Emulator controller driving request and access strobes.
// Assumes: Accesses only while the core is halted.
// Notes:   Released lines show inverted data, not the old value.
`timescale 1ns/1ns
module emc_ice_model (
	input  wire logic         core_clk,
	output logic              emulation_request,
	output emc_pkg::emc_acc_t acc
);
	import emc_pkg::*;
	initial begin
		emulation_request = 1'b0;
		acc = '{1'b1, 1'b1, 1'b1, 8'h00, 8'h00};
	end
	task automatic halt(input logic on);
		@(posedge core_clk);
		emulation_request <= on;
	endtask : halt
	task automatic access(input logic wr, hi, input logic [7:0] a, d);
		@(posedge core_clk);
		acc <= '{!wr, wr, hi, a, d};
		@(posedge core_clk);
		acc <= '{1'b1, 1'b1, hi, ~a, ~d};
	endtask : access
endmodule : emc_ice_model

/* tb/emulation_mode_control_bench.sv */
// Purpose: Self-checking bench for emc_ctrl.
// Assumes: Type straps are set before each reset.
// Notes:   Emulation is run in the standard type.
`timescale 1ns/1ns
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin \
	miscompares++; $display("mismatch %s exp %h got %h", n, e, s); end end
module emulation_mode_control_bench;
	import emc_pkg::*;
	typedef struct packed {logic tsn, ea, da, adv, sp;} emc_row_t;
	emc_row_t rows [3] = '{5'b10010, 5'b00101, 5'b01000};
	logic core_clk = 1'b0, rst_n = 1'b0, tsn = 1'b1, ea = 1'b0, da = 1'b0;
	logic sp_i = 1'b0, sp_drv = 1'b0, req, act, run, adv, pull, p0f, p2f;
	logic [7:0] p2c = 8'h01, rdata, ir;
	emc_acc_t acc;
	emc_mem_t mem_in = '{8'h5a, 8'h12, 8'h34, 1'b0, 1'b1, 1'b0}, mem_o;
	int miscompares = 0, cmp_count = 0;
	always #25 core_clk = ~core_clk;
	emc_ice_model i_ice (.core_clk, .emulation_request(req), .acc);
	emc_ctrl i_dut (.core_clk, .rst_n, .type_select_n(tsn),
		.external_access_n(ea), .emulation_request(req),
		.addr_space_select_i(sp_i), .addr_space_select_drv(sp_drv),
		.addr_space_select_o(), .addr_space_select_oe_n(),
		.emulation_active(act), .state1_clock_out(), .acc,
		.acc_rdata(rdata), .core_data_access(da), .core_mem(mem_in),
		.port2_float_control(p2c), .mem_out(mem_o), .strobe_pullup_en(pull),
		.port0_float(p0f), .port2_float(p2f), .advanced_type(adv),
		.core_run(run), .instruction_holding_reg(ir), .pc_value());
	task automatic wrap_up;
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : wrap_up
	task automatic wait_run(input logic v);
		int n = 0;
		while (run !== v && n < 40) begin
			@(posedge core_clk);
			n++;
		end
		#1;
	endtask : wait_run
	task automatic rd(input logic hi, input logic [7:0] a, e);
		i_ice.access(1'b0, hi, a, 8'h00);
		#1;
		`CHK("rdata", e, rdata)
	endtask : rd
	initial begin
		#60000;
		miscompares++;
		wrap_up();
	end
	initial begin
		foreach (rows[i]) begin
			{tsn, ea, da} <= {rows[i].tsn, rows[i].ea, rows[i].da};
			rst_n <= 1'b0;
			repeat (6) @(posedge core_clk);
			rst_n <= 1'b1;
			repeat (4) @(posedge core_clk);
			#1;
			`CHK("type", rows[i].adv, adv)
			`CHK("space", rows[i].sp, i_dut.addr_space_select_o)
			`CHK("oe", 1'b0, i_dut.addr_space_select_oe_n)
			if (rows[i].adv) `CHK("mem", mem_in, mem_o)
		end
		i_ice.halt(1'b1);
		wait_run(1'b0);
		`CHK("active", 1'b1, act)
		`CHK("oe", 1'b1, i_dut.addr_space_select_oe_n)
		i_ice.access(1'b1, 1'b1, 8'h00, 8'ha5);
		rd(1'b1, 8'h00, 8'ha5);
		`CHK("pc", 16'h00a5, i_dut.pc_value)
		i_ice.access(1'b1, 1'b1, 8'h02, 8'h3c);
		rd(1'b1, 8'h02, 8'h3c);
		i_ice.access(1'b1, 1'b0, 8'hff, 8'h69);
		rd(1'b0, 8'hff, 8'h69);
		@(posedge core_clk);
		{sp_i, sp_drv, tsn} <= 3'h7;
		@(posedge core_clk);
		#1;
		`CHK("pull", 1'b1, pull)
		`CHK("p0", 1'b1, p0f)
		`CHK("p2", 1'b1, p2f)
		@(posedge core_clk);
		p2c <= 8'h00;
		@(posedge core_clk);
		#1;
		`CHK("p2off", 1'b0, p2f)
		i_ice.access(1'b1, 1'b0, 8'hff, 8'h00);
		sp_drv <= 1'b0;
		rd(1'b0, 8'hff, 8'h69);
		`CHK("keep", 1'b0, adv)
		i_ice.halt(1'b0);
		wait_run(1'b1);
		`CHK("ir", 8'h00, ir)
		repeat (8) @(posedge core_clk);
		#1;
		`CHK("done", 1'b0, act)
		wrap_up();
	end
endmodule : emulation_mode_control_bench
